// file: include/hsc_pkg.sv
/*
 * Constants and types shared by the gated high-speed counter block.
 * Assumes a single 125 MHz system clock and no register bus.
 */
`default_nettype none

package hsc_pkg;

	// ==================================================================
	// Sizes
	localparam int NUM_CNT      = 4;
	localparam int CNT_W        = 32;
	localparam int TASK_W       = 16;
	localparam int SEL_W        = 2;
	localparam int SYNC_STAGES  = 3;

	// ==================================================================
	// Timing
	localparam int CLK_HZ       = 125_000_000;
	localparam int MAX_IN_HZ    = 100_000;
	// Clock cycles per input period at the fastest supported pulse rate.
	localparam int IN_PERIOD_CYC = CLK_HZ / MAX_IN_HZ;

	// ==================================================================
	// Reset values
	localparam logic [CNT_W-1:0] CNT_RST  = 32'h0000_0000;
	localparam logic             GATE_RST = 1'h0;

	// ==================================================================
	// Modes
	typedef enum logic {
		IN_UP_PULSE,
		IN_QUAD_X4
	} in_mode_t;

	typedef enum logic {
		RST_SOFT,
		RST_Z_SOFT
	} rst_method_t;

	typedef enum logic {
		CMP_TARGET,
		CMP_RANGE
	} cmp_mode_t;

endpackage : hsc_pkg

`default_nettype wire

// file: logic/gated_high_speed_counter.sv
/*
 * Four gated high-speed pulse counters with software reset, phase-Z reset,
 * quadrature decoding, target or range comparison and input latching.
 * Assumes encoder and latch inputs are asynchronous pins and all control
 * bits come from logic on clk_sys.
 */
// Notes on behaviour
// - A set gate bit freezes its counter; pulses are ignored, value held.
// - Clearing the gate bit lets the counter count and update again.
// - Gate is ignored under phase-Z plus software reset with reset bit set.
// - All gate bits are cleared at power-up.
// - Reaching the target or entering the range raises the configured task.
// - A rising edge on a latch input captures the selected counter value.
// - Quadrature mode counts every edge of both phases, fourfold.
// - Input pulses are accepted up to the maximum input frequency setting.
// - Software may overwrite a counter value, including clearing to zero.
// - Per counter, comparison stops or continues after a counter reset.
// - Soft reset clears on reset bit rising; Z reset clears on Z while set.
`timescale 1ns/10ps
`default_nettype none

module gated_high_speed_counter
	import hsc_pkg::*;
#(
	parameter int NUM = NUM_CNT,
	parameter int W   = CNT_W
) (
	// Clock and reset
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	// Encoder pins
	input  wire logic [NUM-1:0]               phase_a,
	input  wire logic [NUM-1:0]               phase_b,
	input  wire logic [NUM-1:0]               phase_z,
	// Configuration
	input  wire logic [NUM-1:0]               quad_mode,
	input  wire logic [NUM-1:0]               z_reset_mode,
	input  wire logic [NUM-1:0]               range_mode,
	input  wire logic [NUM-1:0]               cmp_continue,
	// Gate control
	input  wire logic [NUM-1:0]               gate_wr,
	input  wire logic [NUM-1:0]               gate_wdata,
	// Software reset bits
	input  wire logic [NUM-1:0]               soft_reset_bit,
	// Present value overwrite
	input  wire logic [NUM-1:0]               pv_wr,
	input  wire logic [NUM-1:0][W-1:0]        pv_wdata,
	// Comparison settings
	input  wire logic [NUM-1:0]               cmp_start,
	input  wire logic [NUM-1:0][W-1:0]        cmp_target,
	input  wire logic [NUM-1:0][W-1:0]        cmp_low,
	input  wire logic [NUM-1:0][W-1:0]        cmp_high,
	input  wire logic [NUM-1:0][TASK_W-1:0]   cmp_task,
	// Latch inputs
	input  wire logic                         latch_interrupt_input_a,
	input  wire logic                         latch_interrupt_input_b,
	input  wire logic [SEL_W-1:0]             latch_sel_a,
	input  wire logic [SEL_W-1:0]             latch_sel_b,
	// Status and results
	output logic [NUM-1:0][W-1:0]             present_count_value,
	output logic [NUM-1:0]                    gate_state,
	output logic [NUM-1:0]                    cmp_active,
	output logic [NUM-1:0]                    task_fire,
	output logic [NUM-1:0][TASK_W-1:0]        task_num,
	output logic [W-1:0]                      latch_value_a,
	output logic [W-1:0]                      latch_value_b,
	output logic                              latch_strobe_a,
	output logic                              latch_strobe_b
);

	// ==================================================================
	// Latch input synchronisers and edge detection
	logic [SYNC_STAGES-1:0] lat_a_sync_q;
	logic [SYNC_STAGES-1:0] lat_b_sync_q;
	logic                   lat_a_filt_q;
	logic                   lat_b_filt_q;
	logic                   lat_a_rise;
	logic                   lat_b_rise;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lat_a_sync_q <= '0;
			lat_b_sync_q <= '0;
		end else begin
			lat_a_sync_q <= {lat_a_sync_q[SYNC_STAGES-2:0], latch_interrupt_input_a};
			lat_b_sync_q <= {lat_b_sync_q[SYNC_STAGES-2:0], latch_interrupt_input_b};
		end
	end

	assign lat_a_rise = (lat_a_sync_q[1] == lat_a_sync_q[2]) && lat_a_sync_q[2] && !lat_a_filt_q;
	assign lat_b_rise = (lat_b_sync_q[1] == lat_b_sync_q[2]) && lat_b_sync_q[2] && !lat_b_filt_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lat_a_filt_q <= 1'h0;
			lat_b_filt_q <= 1'h0;
		end else begin
			if (lat_a_sync_q[1] == lat_a_sync_q[2]) begin
				lat_a_filt_q <= lat_a_sync_q[2];
			end
			if (lat_b_sync_q[1] == lat_b_sync_q[2]) begin
				lat_b_filt_q <= lat_b_sync_q[2];
			end
		end
	end

	// Captures the selected counter's value on each latch input's rising edge.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			latch_value_a  <= W'(CNT_RST);
			latch_value_b  <= W'(CNT_RST);
			latch_strobe_a <= 1'h0;
			latch_strobe_b <= 1'h0;
		end else begin
			latch_strobe_a <= lat_a_rise;
			latch_strobe_b <= lat_b_rise;
			if (lat_a_rise) begin
				latch_value_a <= present_count_value[latch_sel_a];
			end
			if (lat_b_rise) begin
				latch_value_b <= present_count_value[latch_sel_b];
			end
		end
	end

	// ==================================================================
	// Counter channels
	for (genvar i = 0; i < NUM; i++) begin : g_cnt
		// Three-stage synchronisers; a level is taken once stages 2 and 3 agree.
		// At 125 MHz this leaves far more than four samples per phase at the
		// fastest input rate, so no edge is missed.
		logic [SYNC_STAGES-1:0] a_sync_q;
		logic [SYNC_STAGES-1:0] b_sync_q;
		logic [SYNC_STAGES-1:0] z_sync_q;
		logic                   a_q;
		logic                   b_q;
		logic                   z_q;
		logic                   a_d;
		logic                   b_d;
		logic                   z_rise;
		logic                   srst_q;
		logic                   gate_q;
		logic                   freeze;
		logic                   step_up;
		logic                   step_dn;
		logic                   clear_evt;
		logic [W-1:0]           cnt_d;
		logic                   in_rng_q;
		logic                   in_rng_d;
		logic                   cmp_en_q;

		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				a_sync_q <= '0;
				b_sync_q <= '0;
				z_sync_q <= '0;
			end else begin
				a_sync_q <= {a_sync_q[SYNC_STAGES-2:0], phase_a[i]};
				b_sync_q <= {b_sync_q[SYNC_STAGES-2:0], phase_b[i]};
				z_sync_q <= {z_sync_q[SYNC_STAGES-2:0], phase_z[i]};
			end
		end

		assign a_d    = (a_sync_q[1] == a_sync_q[2]) ? a_sync_q[2] : a_q;
		assign b_d    = (b_sync_q[1] == b_sync_q[2]) ? b_sync_q[2] : b_q;
		assign z_rise = (z_sync_q[1] == z_sync_q[2]) && z_sync_q[2] && !z_q;

		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				a_q    <= 1'h0;
				b_q    <= 1'h0;
				z_q    <= 1'h0;
				srst_q <= 1'h0;
			end else begin
				a_q    <= a_d;
				b_q    <= b_d;
				if (z_sync_q[1] == z_sync_q[2]) begin
					z_q <= z_sync_q[2];
				end
				srst_q <= soft_reset_bit[i];
			end
		end

		// Decodes direction from the old and new phase pair.
		always_comb begin
			step_up = 1'h0;
			step_dn = 1'h0;
			if (quad_mode[i] == IN_QUAD_X4) begin
				// Every edge of either phase is one count.
				if (a_d != a_q && b_d == b_q) begin
					step_up = (a_d != b_d);
					step_dn = (a_d == b_d);
				end else if (b_d != b_q && a_d == a_q) begin
					step_up = (a_d == b_d);
					step_dn = (a_d != b_d);
				end
			end else begin
				step_up = a_d && !a_q;
			end
		end

		// Gate register, cleared at reset and written by software.
		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				gate_q <= GATE_RST;
			end else if (gate_wr[i]) begin
				gate_q <= gate_wdata[i];
			end
		end

		assign freeze = gate_q && !(z_reset_mode[i] == RST_Z_SOFT && soft_reset_bit[i]);

		always_comb begin
			if (z_reset_mode[i] == RST_Z_SOFT) begin
				clear_evt = soft_reset_bit[i] && z_rise;
			end else begin
				clear_evt = soft_reset_bit[i] && !srst_q;
			end
		end

		always_comb begin
			cnt_d = present_count_value[i];
			if (clear_evt) begin
				cnt_d = W'(CNT_RST);
			end else if (pv_wr[i]) begin
				cnt_d = pv_wdata[i];
			end else if (!freeze && step_up) begin
				cnt_d = present_count_value[i] + W'(1);
			end else if (!freeze && step_dn) begin
				cnt_d = present_count_value[i] - W'(1);
			end
			// A frozen counter falls through here and keeps its value.
		end

		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				present_count_value[i] <= W'(CNT_RST);
			end else begin
				present_count_value[i] <= cnt_d;
			end
		end

		// Comparison enable: armed by software, dropped by a reset when the
		// counter is set to stop comparing after a reset.
		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				cmp_en_q <= 1'h0;
			end else if (cmp_start[i]) begin
				cmp_en_q <= 1'h1;
			end else if (clear_evt && !cmp_continue[i]) begin
				cmp_en_q <= 1'h0;
			end
		end

		assign in_rng_d = (cnt_d >= cmp_low[i]) && (cnt_d <= cmp_high[i]);

		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				in_rng_q    <= 1'h0;
				task_fire[i] <= 1'h0;
				task_num[i]  <= '0;
			end else begin
				in_rng_q     <= in_rng_d;
				task_fire[i] <= 1'h0;
				if (cmp_en_q) begin
					if (range_mode[i] == CMP_RANGE) begin
						if (in_rng_d && !in_rng_q) begin
							task_fire[i] <= 1'h1;
							task_num[i]  <= cmp_task[i];
						end
					end else if (cnt_d == cmp_target[i] && present_count_value[i] != cmp_target[i]) begin
						task_fire[i] <= 1'h1;
						task_num[i]  <= cmp_task[i];
					end
				end
			end
		end

		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				gate_state[i] <= GATE_RST;
				cmp_active[i] <= 1'h0;
			end else begin
				gate_state[i] <= gate_q;
				cmp_active[i] <= cmp_en_q;
			end
		end
	end : g_cnt

endmodule : gated_high_speed_counter

`default_nettype wire

// file: test/gated_high_speed_counter_assertions.sv
/* Port checker of the counter block, bound to its top module.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
// ==========
// Properties
module gated_high_speed_counter_assertions
	import hsc_pkg::*;
#(parameter int NUM = NUM_CNT, parameter int W = CNT_W) (
	// Clock and reset
	input wire logic clk_sys, rst_n,
	// Controls
	input wire logic [NUM-1:0] gate_wr, gate_wdata, soft_reset_bit, z_reset_mode, cmp_continue, range_mode, pv_wr,
	input wire logic [NUM-1:0][W-1:0] pv_wdata, cmp_target,
	input wire logic [NUM-1:0][TASK_W-1:0] cmp_task,
	input wire logic [SEL_W-1:0] latch_sel_a,
	// Results
	input wire logic [NUM-1:0][W-1:0] present_count_value,
	input wire logic [NUM-1:0] gate_state, cmp_active, task_fire,
	input wire logic [NUM-1:0][TASK_W-1:0] task_num,
	input wire logic [W-1:0] latch_value_a,
	input wire logic latch_strobe_a
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_gate_hold: assert property (
		gate_state[0] && !$past(gate_wr[0]) && !gate_wr[0] && !pv_wr[0] && !soft_reset_bit[0]
		|=> $stable(present_count_value[0])) else $error("gated count moved");
	a_gate_state: assert property (
		gate_wr[0] ##1 !gate_wr[0] |=> gate_state[0] == $past(gate_wdata[0], 2)) else $error("gate state wrong");
	a_soft_clear: assert property (
		!z_reset_mode[0] && $rose(soft_reset_bit[0]) |=> present_count_value[0] == '0) else $error("no soft clear");
	a_pv_load: assert property (
		pv_wr[0] && !soft_reset_bit[0] |=> present_count_value[0] == $past(pv_wdata[0])) else $error("pv not loaded");
	a_fire_task: assert property (
		task_fire[0] |-> (cmp_active[0] && task_num[0] == $past(cmp_task[0])) ##1 !task_fire[0])
		else $error("bad task fire");
	a_target_val: assert property (
		task_fire[0] && !range_mode[0] |-> present_count_value[0] == cmp_target[0]) else $error("fire off target");
	a_latch_cap: assert property (
		latch_strobe_a |-> latch_value_a == $past(present_count_value[latch_sel_a])) else $error("bad latch value");
	a_arm_keep: assert property (
		cmp_continue[0] && cmp_active[0] && $rose(soft_reset_bit[0]) |=> ##1 cmp_active[0])
		else $error("compare stopped");
endmodule : gated_high_speed_counter_assertions
bind gated_high_speed_counter gated_high_speed_counter_assertions #(.NUM(NUM), .W(W)) u_chk (.clk_sys, .rst_n,
	.gate_wr, .gate_wdata, .soft_reset_bit, .z_reset_mode, .cmp_continue, .range_mode, .pv_wr, .pv_wdata, .cmp_target,
	.cmp_task, .latch_sel_a, .present_count_value, .gate_state, .cmp_active, .task_fire, .task_num, .latch_value_a,
	.latch_strobe_a);
`default_nettype wire

// file: test/encoder_model.sv
/* Encoder model: two phases and an index line per channel.
   Assumes step requests on clk_sys, spaced beyond the input filter. */
`timescale 1ns/10ps
`default_nettype none
// ==========
// Gray-coded position, one edge per request
module encoder_model #(parameter int N = 4) (
	// Clock and requests
	input wire logic         clk_sys,
	input wire logic [N-1:0] step, dir, index,
	// Encoder pins
	output logic     [N-1:0] phase_a, phase_b, phase_z
);
	logic [N-1:0][1:0] pos_q = '0;
	logic [N-1:0]      z_q   = '0;
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < N; i++) begin
			if (step[i]) begin
				pos_q[i] <= dir[i] ? pos_q[i] - 2'h1 : pos_q[i] + 2'h1;
			end
		end
		z_q <= index;
	end
	always_comb begin
		for (int i = 0; i < N; i++) begin
			phase_a[i] = pos_q[i][1];
			phase_b[i] = pos_q[i][1] ^ pos_q[i][0];
		end
	end
	assign phase_z = z_q;
endmodule : encoder_model
`default_nettype wire

// file: test/gated_high_speed_counter_test.sv
/* Bench of the counter block with the encoder model on its pins.
   Assumes the package constants and a 125 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module gated_high_speed_counter_test;
	import hsc_pkg::*;
	// ==========
	// Signals
	logic clk_sys = 1'h0, rst_n = 1'h0, latch_interrupt_input_a = 1'h0, latch_interrupt_input_b = 1'h0, up;
	logic [3:0] step = 4'h0, dir = 4'h0, index = 4'h0, gate_wr = 4'h0, gate_wdata = 4'h0, soft_reset_bit = 4'h0;
	logic [3:0] pv_wr = 4'h0, cmp_start = 4'h0, quad_mode = 4'hb, z_reset_mode = 4'h2, range_mode = 4'h8;
	logic [3:0] cmp_continue = 4'hd, phase_a, phase_b, phase_z, gate_state, cmp_active, task_fire;
	logic [3:0][31:0] pv_wdata = '0, cmp_target = '0, cmp_low = '0, cmp_high = '0, present_count_value;
	logic [3:0][15:0] cmp_task = '0, task_num;
	logic [1:0] latch_sel_a = 2'h3, latch_sel_b = 2'h3;
	logic [31:0] latch_value_a, latch_value_b, base;
	logic latch_strobe_a, latch_strobe_b;
	logic [15:0] rnd = 16'h0021;
	int errors = 0, checks_done = 0, fires = 0, strobes = 0, f0;
	gated_high_speed_counter u_gated_high_speed_counter (.clk_sys, .rst_n, .phase_a, .phase_b, .phase_z, .quad_mode,
		.z_reset_mode, .range_mode, .cmp_continue, .gate_wr, .gate_wdata, .soft_reset_bit, .pv_wr, .pv_wdata, .cmp_start,
		.cmp_target, .cmp_low, .cmp_high, .cmp_task, .latch_interrupt_input_a, .latch_interrupt_input_b, .latch_sel_a,
		.latch_sel_b, .present_count_value, .gate_state, .cmp_active, .task_fire, .task_num, .latch_value_a,
		.latch_value_b, .latch_strobe_a, .latch_strobe_b);
	encoder_model u_encoder_model (.clk_sys, .step, .dir, .index, .phase_a, .phase_b, .phase_z);
	initial forever #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) fires <= fires + int'(task_fire[0] === 1'h1) + int'(task_fire[3] === 1'h1);
	always @(posedge clk_sys) strobes <= strobes + int'(latch_strobe_a === 1'h1) + int'(latch_strobe_b === 1'h1);
	// ==========
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	function automatic logic [31:0] mag(input logic [31:0] v);
		return v[31] ? 32'h0 - v : v;
	endfunction : mag
	task automatic chk(input string name, input logic [31:0] exp_v, input logic [31:0] seen);
		checks_done++;
		if (seen !== exp_v) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp_v, seen);
		end
	endtask : chk
	task automatic steps(input int c, input int n, input logic d, input int gap);
		repeat (n) begin
			@(posedge clk_sys);
			step[c] <= 1'h1;
			dir[c] <= d;
			rnd = lfsr(rnd);
			@(posedge clk_sys);
			step[c] <= 1'h0;
			repeat (gap + int'(rnd[3:0])) @(posedge clk_sys);
		end
		repeat (8) @(posedge clk_sys);
	endtask : steps
	task automatic strobe(input logic [3:0] g, input logic [3:0] p, input logic [3:0] s);
		@(posedge clk_sys);
		{gate_wr, pv_wr, cmp_start} <= {g, p, s};
		@(posedge clk_sys);
		{gate_wr, pv_wr, cmp_start} <= 12'h0;
		repeat (2) @(posedge clk_sys);
	endtask : strobe
	task automatic stop_test;
		$display("checks_done %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (60000) @(posedge clk_sys);
		errors++;
		stop_test;
	end
	// ==========
	// Scenarios
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'h1;
		repeat (2) @(posedge clk_sys);
		chk("gate_reset", 32'h0, 32'(gate_state));
		steps(0, 20, 1'h0, IN_PERIOD_CYC / 4);
		up = present_count_value[0][31];
		chk("quad_fwd", 32'h14, mag(present_count_value[0]));
		steps(0, 20, 1'h1, 8);
		chk("quad_back", 32'h0, present_count_value[0]);
		steps(2, 8, up, 8);
		chk("pulse_mode", 32'h2, present_count_value[2]);
		gate_wdata <= 4'h3;
		strobe(4'h3, 4'h0, 4'h0);
		base = present_count_value[0];
		steps(0, 8, up, 8);
		chk("gated", base, present_count_value[0]);
		chk("gate_bits", 32'h3, 32'(gate_state));
		gate_wdata <= 4'h2;
		strobe(4'h1, 4'h0, 4'h0);
		steps(0, 5, up, 8);
		chk("resumed", base + 32'h5, present_count_value[0]);
		rnd = lfsr(rnd);
		cmp_target[0] <= base + 32'h8;
		cmp_task <= {rnd, 16'h0, 16'h0, ~rnd};
		cmp_low[3] <= 32'h2;
		cmp_high[3] <= 32'h3;
		strobe(4'h0, 4'h0, 4'h9);
		f0 = fires;
		steps(0, 4, up, 8);
		steps(3, 4, up, 8);
		chk("fires", 32'h2, 32'(fires - f0));
		chk("task0", 32'(cmp_task[0]), 32'(task_num[0]));
		chk("task3", 32'(cmp_task[3]), 32'(task_num[3]));
		pv_wdata[0] <= {rnd, rnd};
		strobe(4'h0, 4'h1, 4'h2);
		chk("pv_load", {rnd, rnd}, present_count_value[0]);
		soft_reset_bit <= 4'h3;
		repeat (3) @(posedge clk_sys);
		chk("soft_clear", 32'h0, present_count_value[0]);
		chk("armed_on", 32'h1, 32'(cmp_active[0]));
		steps(1, 4, up, 8);
		chk("gate_off_z", 32'h4, present_count_value[1]);
		index[1] <= 1'h1;
		repeat (10) @(posedge clk_sys);
		index[1] <= 1'h0;
		repeat (8) @(posedge clk_sys);
		chk("z_clear", 32'h0, present_count_value[1]);
		chk("armed_off", 32'h0, 32'(cmp_active[1]));
		soft_reset_bit <= 4'h0;
		steps(1, 4, up, 8);
		chk("gated_z", 32'h0, present_count_value[1]);
		{latch_sel_a, latch_sel_b, latch_interrupt_input_a} <= 5'h1;
		repeat (8) @(posedge clk_sys);
		steps(0, 6, up, 8);
		latch_interrupt_input_b <= 1'h1;
		repeat (8) @(posedge clk_sys);
		chk("latch_a", 32'h0, latch_value_a);
		chk("latch_span", 32'h6, latch_value_b - latch_value_a);
		chk("latch_strobes", 32'h2, 32'(strobes));
		stop_test;
	end
endmodule : gated_high_speed_counter_test
`default_nettype wire
